//--- dopb_bank.sv
// Purpose: parameter bank of a programmable drive option module
// Assumes: parameter and program-variable ports are both on ref_clk_in
// Notes:   drive-side status inputs are synchronised by two flip-flops
//          and a drive word is only taken once two samples agree
`timescale 1ns/1ps
`include "dopb_params.svh"

// Behaviour
// [R1] six sets of 100 signed 32-bit registers
// [R2] sets a,b,c,d saved on request or undervoltage
// [R3] sets 72 and 73 hold link data, unsaved
// [R4] parameter and variable paths share storage
// [R5] error code reads run-time error, 0..9999
// [R6] error code cleared on reset, program start
// [R7] writing 1070 triggers warm restart
// [R8] failing task code, zero when no error
// [R9] task code valid only in error task
// [R10] position: coarse high half, fine low half
// [R11] marker pulses never alter positions
// [R12] feedback turns read-only unsigned 16-bit
// [R13] reference position and turns read-only
// [R14] drive mode reports actual mode code
// [R15] write loads control, read returns status
// [R16] b0..b3 enable, forward, jog, reverse
// [R17] b9..b12 gate sequencing targets
// [R18] b5,b6 presets gated by b14,b15
// [R19] b4 set trips drive immediately
// [R20] b7,b8,b13 set application flags 1..3
// [R21] status word bit map, b15 unused
// [R22] cleared gate keeps previous target value
// [R23] writes to read-only parameters ignored
module dopb_bank #(
  parameter int unsigned SETS    = 6,     // number of register sets
  parameter int unsigned REGS    = 100,   // registers per set
  parameter int unsigned DATA_W  = 32     // register width
) (
  // clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              rst_n_in,
  // parameter port (menu/index addressing)
  input  wire logic              par_wr_in,
  input  wire logic              par_rd_in,
  input  wire logic [7:0]        par_menu_in,
  input  wire logic [6:0]        par_idx_in,
  input  wire logic [DATA_W-1:0] par_wdata_in,
  output logic      [DATA_W-1:0] par_rdata_out,
  output logic                   par_ack_out,
  // program variable port (set/index addressing)
  input  wire logic              var_wr_in,
  input  wire logic              var_rd_in,
  input  wire logic [5:0]        var_set_in,
  input  wire logic [6:0]        var_idx_in,
  input  wire logic [DATA_W-1:0] var_wdata_in,
  output logic      [DATA_W-1:0] var_rdata_out,
  // program runtime events
  input  wire logic              prog_start_in,
  input  wire logic              rt_error_in,
  input  wire logic [15:0]       rt_error_code_in,
  input  wire logic [7:0]        rt_error_task_in,
  // save control
  input  wire logic              save_req_in,
  input  wire logic              undervolt_in,
  output logic                   save_out,
  output logic      [3:0]        save_sets_out,
  output logic                   warm_restart_out,
  // drive side readouts (asynchronous)
  input  wire logic [31:0]       fb_pos_in,
  input  wire logic [15:0]       fb_turns_in,
  input  wire logic [31:0]       ref_pos_in,
  input  wire logic [15:0]       ref_turns_in,
  input  wire logic [15:0]       drive_mode_in,
  input  wire logic [14:0]       drive_status_in,
  // drive control outputs
  output logic                   drive_enable_out,
  output logic                   run_forward_out,
  output logic                   jog_out,
  output logic                   run_reverse_out,
  output logic      [1:0]        preset_sel_out,
  output logic                   user_trip_out,
  output logic      [3:1]        app_flag_out
);

  // register storage: one flat array, both ports index it [R4]
  // no reset: contents are undefined until written, which keeps
  // the array mappable onto a plain memory
  logic [DATA_W-1:0] regs [SETS*REGS];

  // first and second synchroniser stages for drive readouts
  logic [31:0] fb_pos_m, fb_pos_s;
  logic [15:0] fb_turns_m, fb_turns_s;
  logic [31:0] ref_pos_m, ref_pos_s;
  logic [15:0] ref_turns_m, ref_turns_s;
  logic [15:0] mode_m, mode_s;
  logic [14:0] stat_m, stat_s;
  logic        uv_m, uv_s, uv_d;   // undervoltage level and its delay

  // third stage and settled copy of each drive word
  logic [31:0] fb_pos_d, fb_pos_h;
  logic [15:0] fb_turns_d, fb_turns_h;
  logic [31:0] ref_pos_d, ref_pos_h;
  logic [15:0] ref_turns_d, ref_turns_h;
  logic [15:0] mode_d, mode_h;
  logic [14:0] stat_d, stat_h;

  // held error state
  // set by an error, cleared by reset or a program start
  logic [15:0] error_code;         // run-time error code
  logic [7:0]  fail_task;          // task that raised the error

  // decode results
  // all decode is combinational off the request inputs
  logic [2:0]  par_set_num;        // set number from menu
  logic        par_is_set;         // menu addresses a register set
  logic        par_idx_ok;         // index in 00..99
  logic        var_idx_ok;         // variable index in range
  logic [2:0]  var_set_num;        // set number from one-hot code
  logic        var_set_ok;         // code is a legal one-hot set
  logic        wr_err;             // write to error-code register
  logic        wr_ctrl;            // write to control word
  logic [15:0] cw;                 // control word being written

  // synchronise drive-side inputs; only second stage is read
  // the drive runs on its own clock, so every word crosses here
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fb_pos_m    <= 32'h0000_0000;
      fb_pos_s    <= 32'h0000_0000;
      fb_turns_m  <= 16'h0000;
      fb_turns_s  <= 16'h0000;
      ref_pos_m   <= 32'h0000_0000;
      ref_pos_s   <= 32'h0000_0000;
      ref_turns_m <= 16'h0000;
      ref_turns_s <= 16'h0000;
      mode_m      <= 16'h0000;
      mode_s      <= 16'h0000;
      stat_m      <= 15'h0000;
      stat_s      <= 15'h0000;
      uv_m        <= 1'b0;
      uv_s        <= 1'b0;
      uv_d        <= 1'b0;
    end else begin
      // positions come straight from the drive; no marker input exists [R11]
      fb_pos_m    <= fb_pos_in;
      fb_pos_s    <= fb_pos_m;
      fb_turns_m  <= fb_turns_in;
      fb_turns_s  <= fb_turns_m;
      ref_pos_m   <= ref_pos_in;
      ref_pos_s   <= ref_pos_m;
      ref_turns_m <= ref_turns_in;
      ref_turns_s <= ref_turns_m;
      mode_m      <= drive_mode_in;
      mode_s      <= mode_m;
      stat_m      <= drive_status_in;
      stat_s      <= stat_m;
      // undervoltage is one bit, so two stages alone are safe
      uv_m        <= undervolt_in;
      uv_s        <= uv_m;
      uv_d        <= uv_s;
    end
  end

  // settle stage: a word crossing clocks can be caught torn,
  // some bits old and some new, so it is taken only when
  // two successive samples agree
  // limitation: a word that moves on every edge keeps its old value
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fb_pos_d    <= 32'h0000_0000;
      fb_pos_h    <= 32'h0000_0000;
      fb_turns_d  <= 16'h0000;
      fb_turns_h  <= 16'h0000;
      ref_pos_d   <= 32'h0000_0000;
      ref_pos_h   <= 32'h0000_0000;
      ref_turns_d <= 16'h0000;
      ref_turns_h <= 16'h0000;
      mode_d      <= 16'h0000;
      mode_h      <= 16'h0000;
      stat_d      <= 15'h0000;
      stat_h      <= 15'h0000;
    end else begin
      // one more sample of each synchronised word
      fb_pos_d    <= fb_pos_s;
      fb_turns_d  <= fb_turns_s;
      ref_pos_d   <= ref_pos_s;
      ref_turns_d <= ref_turns_s;
      mode_d      <= mode_s;
      stat_d      <= stat_s;
      // take a word once it reads alike on two edges
      if (fb_pos_s == fb_pos_d) fb_pos_h <= fb_pos_d;
      if (fb_turns_s == fb_turns_d) fb_turns_h <= fb_turns_d;
      if (ref_pos_s == ref_pos_d) ref_pos_h <= ref_pos_d;
      if (ref_turns_s == ref_turns_d) ref_turns_h <= ref_turns_d;
      if (mode_s == mode_d) mode_h <= mode_d;
      if (stat_s == stat_d) stat_h <= stat_d;
    end
  end

  // address decode of both ports
  always_comb begin
    par_is_set  = 1'b1;
    par_set_num = 3'd0;
    // menus outside the six sets fall to the default
    unique case (par_menu_in)
      `DOPB_MENU_SET_A:    par_set_num = 3'd0;
      `DOPB_MENU_SET_B:    par_set_num = 3'd1;
      `DOPB_MENU_LINK_OUT: par_set_num = 3'd2;  // outgoing link data [R3]
      `DOPB_MENU_LINK_IN:  par_set_num = 3'd3;  // incoming link data [R3]
      `DOPB_MENU_SET_C:    par_set_num = 3'd4;
      `DOPB_MENU_SET_D:    par_set_num = 3'd5;
      default:             par_is_set  = 1'b0;
    endcase
    // indices 100..127 lie outside every set and are refused
    par_idx_ok = (par_idx_in < `DOPB_REGS_PER_SET);
    var_idx_ok = (var_idx_in < `DOPB_REGS_PER_SET);
    // the variable port names its set by a one-hot code
    var_set_ok = 1'b1;
    var_set_num = 3'd0;
    unique case (var_set_in)
      dopb_pkg::DOPB_SET_A:   var_set_num = 3'd0;
      dopb_pkg::DOPB_SET_B:   var_set_num = 3'd1;
      dopb_pkg::DOPB_SET_OUT: var_set_num = 3'd2;
      dopb_pkg::DOPB_SET_IN:  var_set_num = 3'd3;
      dopb_pkg::DOPB_SET_C:   var_set_num = 3'd4;
      dopb_pkg::DOPB_SET_D:   var_set_num = 3'd5;
      default:                var_set_ok  = 1'b0;  // not one-hot: ignored
    endcase
    // single-register targets of the parameter port
    wr_err  = par_wr_in && (par_menu_in == `DOPB_MENU_STATUS)
              && (par_idx_in == `DOPB_IDX_ERROR_CODE);
    wr_ctrl = par_wr_in && (par_menu_in == `DOPB_MENU_GENERAL)
              && (par_idx_in == `DOPB_IDX_STAT_CTRL);
    // the control word sits in the low half of the write data
    cw      = par_wdata_in[15:0];
  end

  // register set writes; parameter port wins a same-slot collision [R1]
  // the later assignment wins, so the order of the two ifs matters
  always_ff @(posedge ref_clk_in) begin
    // a bad set code or an index past 99 writes nothing
    if (var_wr_in && var_set_ok && var_idx_ok) begin
      regs[int'(var_set_num) * REGS + int'(var_idx_in)] <= var_wdata_in;  // [R4]
    end
    if (par_wr_in && par_is_set && par_idx_ok) begin
      regs[int'(par_set_num) * REGS + int'(par_idx_in)] <= par_wdata_in;  // [R1]
    end
  end

  // error code and failing task; error capture beats the program-start clear, reset beats both
  // a clear in the same cycle would hide the error from its handler
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      error_code <= 16'h0000;                      // [R6]
      fail_task  <= 8'h00;                         // [R8]
    end else if (rt_error_in) begin
      // only run-time codes enter here, clamped to range [R5]
      error_code <= (rt_error_code_in > `DOPB_ERROR_MAX) ?
                    `DOPB_ERROR_MAX : rt_error_code_in;
      fail_task  <= rt_error_task_in;              // [R8]
    end else if (prog_start_in) begin
      // a fresh program run starts with a clean error state
      error_code <= 16'h0000;                      // [R6]
      fail_task  <= 8'h00;                         // no error, reads zero [R8]
    end
  end

  // warm restart pulse; plain writes otherwise leave the code untouched
  // one strobe only; the host carries out the restart itself and
  // a value with any other low half is simply dropped
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      warm_restart_out <= 1'b0;
    end else begin
      warm_restart_out <= wr_err && (cw == `DOPB_RESTART_CODE);  // [R7]
    end
  end

  // save request pulse on command or undervoltage rising edge
  // the edge, not the level, saves: a long brown-out saves once
  // and does not keep the store busy
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      save_out      <= 1'b0;
      save_sets_out <= 4'h0;
    end else begin
      save_out      <= save_req_in || (uv_s && !uv_d);          // [R2]
      // link sets are never among those saved [R3]
      save_sets_out <= 4'hF;                                    // [R2]
    end
  end

  // control word: gated sequencing bits hold when gate clear
  // a write with every gate clear leaves sequencing outputs alone
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      drive_enable_out <= 1'b0;
      run_forward_out  <= 1'b0;
      jog_out          <= 1'b0;
      run_reverse_out  <= 1'b0;
      preset_sel_out   <= 2'b00;
    end else if (wr_ctrl) begin                                 // [R15]
      if (cw[`DOPB_CW_GATE_SEQ])     drive_enable_out <= cw[0]; // [R16] [R17] [R22]
      if (cw[`DOPB_CW_GATE_SEQ + 1]) run_forward_out  <= cw[1]; // [R16] [R17] [R22]
      if (cw[`DOPB_CW_GATE_SEQ + 2]) jog_out          <= cw[2]; // [R16] [R17] [R22]
      if (cw[`DOPB_CW_GATE_SEQ + 3]) run_reverse_out  <= cw[3]; // [R16] [R17] [R22]
      // preset bits have their own gates, b14 and b15
      if (cw[`DOPB_CW_GATE_PRE0]) preset_sel_out[0] <= cw[`DOPB_CW_PRESET0]; // [R18]
      if (cw[`DOPB_CW_GATE_PRE1]) preset_sel_out[1] <= cw[`DOPB_CW_PRESET1]; // [R18]
    end
  end

  // ungated flags and user trip pulse
  // the trip is one strobe; the host latches the trip state
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      app_flag_out  <= 3'b000;
      user_trip_out <= 1'b0;
    end else begin
      user_trip_out <= wr_ctrl && cw[`DOPB_CW_TRIP];             // [R19]
      // the flags follow every control write; they have no gate
      if (wr_ctrl) begin
        app_flag_out <= {cw[`DOPB_CW_FLAG3], cw[`DOPB_CW_FLAG2],
                         cw[`DOPB_CW_FLAG1]};                    // [R20]
      end
    end
  end

  // parameter read path, one cycle latency; read-only regs have no write [R23]
  // unmapped reads are acknowledged and return zero, so a probing
  // master never stalls
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      par_rdata_out <= '0;
      par_ack_out   <= 1'b0;
    end else begin
      par_ack_out <= par_rd_in || par_wr_in;
      if (par_rd_in) begin
        par_rdata_out <= '0;   // unmapped reads return zero
        if (par_is_set && par_idx_ok) begin
          par_rdata_out <= regs[int'(par_set_num) * REGS + int'(par_idx_in)];
        end else if (par_menu_in == `DOPB_MENU_STATUS) begin
          // status menu: error code and failing task
          if (par_idx_in == `DOPB_IDX_ERROR_CODE)
            par_rdata_out <= {16'h0000, error_code};               // [R5]
          else if (par_idx_in == `DOPB_IDX_FAIL_TASK)
            par_rdata_out <= {24'h00_0000, fail_task};             // [R8] [R9]
        end else if (par_menu_in == `DOPB_MENU_GENERAL) begin
          // general menu: settled drive readouts and the status word
          unique case (par_idx_in)
            `DOPB_IDX_FB_POS:     par_rdata_out <= fb_pos_h;       // [R10]
            `DOPB_IDX_FB_TURNS:   par_rdata_out <= {16'h0000, fb_turns_h};  // [R12]
            `DOPB_IDX_REF_POS:    par_rdata_out <= ref_pos_h;      // [R13]
            `DOPB_IDX_REF_TURNS:  par_rdata_out <= {16'h0000, ref_turns_h}; // [R13]
            `DOPB_IDX_DRIVE_MODE: par_rdata_out <= {{16{mode_h[15]}}, mode_h}; // [R14]
            `DOPB_IDX_STAT_CTRL:  par_rdata_out <= {17'h0_0000, stat_h}; // [R15] [R21]
            default:              par_rdata_out <= '0;
          endcase
        end
      end
    end
  end

  // variable read path, one cycle latency
  // this port has no acknowledge; data stands from the edge after
  // the strobe until the next read
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      var_rdata_out <= '0;
    end else if (var_rd_in) begin
      var_rdata_out <= (var_set_ok && var_idx_ok) ?
                       regs[int'(var_set_num) * REGS + int'(var_idx_in)] : '0;  // [R4]
    end
  end

endmodule // dopb_bank

//--- dopb_params.svh
// Purpose: constants for the drive option parameter bank
// Assumes: parameters addressed as set/menu number plus index 00..99
// Notes:   menu numbers are the decimal parameter groups of the bank
`ifndef DOPB_PARAMS_SVH
`define DOPB_PARAMS_SVH

// menu numbers of the six register sets and of the status and general menus
`define DOPB_MENU_SET_A      8'h46
`define DOPB_MENU_SET_B      8'h47
`define DOPB_MENU_LINK_OUT   8'h48
`define DOPB_MENU_LINK_IN    8'h49
`define DOPB_MENU_SET_C      8'h4A
`define DOPB_MENU_SET_D      8'h4B
`define DOPB_MENU_STATUS     8'h58
`define DOPB_MENU_GENERAL    8'h5A

// register indices within status and general menus
`define DOPB_IDX_ERROR_CODE  7'h01
`define DOPB_IDX_FAIL_TASK   7'h02
`define DOPB_IDX_FB_POS      7'h01
`define DOPB_IDX_FB_TURNS    7'h02
`define DOPB_IDX_REF_POS     7'h03
`define DOPB_IDX_REF_TURNS   7'h04
`define DOPB_IDX_DRIVE_MODE  7'h0A
`define DOPB_IDX_STAT_CTRL   7'h0B

// values with special meaning
`define DOPB_RESTART_CODE    16'h042E
`define DOPB_ERROR_MAX       16'h270F
`define DOPB_REGS_PER_SET    7'h64

// control word bit positions
`define DOPB_CW_TRIP         4
`define DOPB_CW_PRESET0      5
`define DOPB_CW_PRESET1      6
`define DOPB_CW_FLAG1        7
`define DOPB_CW_FLAG2        8
`define DOPB_CW_GATE_SEQ     9
`define DOPB_CW_FLAG3        13
`define DOPB_CW_GATE_PRE0    14
`define DOPB_CW_GATE_PRE1    15

`endif

//--- dopb_pkg.sv
// Purpose: types for the drive option parameter bank
// Assumes: nothing beyond the params header
// Notes:   set codes select one of the six register sets
package dopb_pkg;
  // register set selector, one-hot
  typedef enum logic [5:0] {
    DOPB_SET_A     = 6'b00_0001,
    DOPB_SET_B     = 6'b00_0010,
    DOPB_SET_OUT   = 6'b00_0100,
    DOPB_SET_IN    = 6'b00_1000,
    DOPB_SET_C     = 6'b01_0000,
    DOPB_SET_D     = 6'b10_0000
  } dopb_set_t;
endpackage

//--- dopb_bank_properties.sv
// Purpose: concurrent checks on the parameter bank ports
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   status/control writes drive most of the checks
`timescale 1ns/1ps
module dopb_bank_properties (
  // clock and reset
  input wire logic        ref_clk_in,
  input wire logic        rst_n_in,
  // parameter port
  input wire logic        par_wr_in,
  input wire logic        par_rd_in,
  input wire logic [7:0]  par_menu_in,
  input wire logic [6:0]  par_idx_in,
  input wire logic [31:0] par_wdata_in,
  input wire logic        par_ack_out,
  // save, restart and drive control
  input wire logic        save_req_in,
  input wire logic        save_out,
  input wire logic [3:0]  save_sets_out,
  input wire logic        warm_restart_out,
  input wire logic        drive_enable_out,
  input wire logic [1:0]  preset_sel_out,
  input wire logic        user_trip_out,
  input wire logic [3:1]  app_flag_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // write to the combined status/control word
  sequence s_ctl_wr;
    par_wr_in && par_menu_in == 8'h5A && par_idx_in == 7'h0B;
  endsequence
  // write of the restart code to the error register
  sequence s_rst_wr;
    par_wr_in && par_menu_in == 8'h58 && par_idx_in == 7'h01 && par_wdata_in == 32'h0000_042E;
  endsequence
  property p_ack; (par_wr_in || par_rd_in) |=> par_ack_out; endproperty
  a_ack: assert property (p_ack) else $error("access not acknowledged");
  property p_restart; s_rst_wr |=> warm_restart_out; endproperty
  a_restart: assert property (p_restart) else $error("no warm restart");
  property p_no_restart; !par_wr_in |=> !warm_restart_out; endproperty
  a_no_restart: assert property (p_no_restart) else $error("stray restart");
  property p_trip; s_ctl_wr ##0 par_wdata_in[4] |=> user_trip_out; endproperty
  a_trip: assert property (p_trip) else $error("user trip missing");
  property p_enable;
    s_ctl_wr ##0 par_wdata_in[9] |=> drive_enable_out == $past(par_wdata_in[0]);
  endproperty
  a_enable: assert property (p_enable) else $error("gated enable wrong");
  property p_keep; s_ctl_wr ##0 !par_wdata_in[9] |=> $stable(drive_enable_out); endproperty
  a_keep: assert property (p_keep) else $error("ungated enable moved");
  property p_preset;
    s_ctl_wr ##0 (par_wdata_in[15:14] == 2'b11) |=> preset_sel_out == $past(par_wdata_in[6:5]);
  endproperty
  a_preset: assert property (p_preset) else $error("preset select wrong");
  property p_flags;
    s_ctl_wr |=> app_flag_out == {$past(par_wdata_in[13]), $past(par_wdata_in[8:7])};
  endproperty
  a_flags: assert property (p_flags) else $error("application flags wrong");
  property p_save; save_req_in |=> save_out && save_sets_out == 4'hF; endproperty
  a_save: assert property (p_save) else $error("save not issued");
endmodule // dopb_bank_properties

bind dopb_bank dopb_bank_properties u_props (.ref_clk_in, .rst_n_in, .par_wr_in, .par_rd_in,
  .par_menu_in, .par_idx_in, .par_wdata_in, .par_ack_out, .save_req_in, .save_out,
  .save_sets_out, .warm_restart_out, .drive_enable_out, .preset_sel_out, .user_trip_out,
  .app_flag_out);

//--- dopb_drive_model.sv
// Purpose: behavioural host drive feeding readouts to the bank
// Assumes: bench picks the operating mode
// Notes:   status reacts to the bank's control outputs
`timescale 1ns/1ps
module dopb_drive_model #(
  parameter logic [31:0] FB_POS  = 32'h1234_0000,  // coarse only, fine part zero
  parameter logic [31:0] REF_POS = 32'hFEDC_8001   // fine part available
) (
  // control from the bank
  input  wire logic        drive_enable_in,
  input  wire logic        run_forward_in,
  input  wire logic        run_reverse_in,
  input  wire logic [15:0] mode_in,
  // readouts to the bank
  output logic      [31:0] fb_pos_out,
  output logic      [15:0] fb_turns_out,
  output logic      [31:0] ref_pos_out,
  output logic      [15:0] ref_turns_out,
  output logic      [15:0] mode_out,
  output logic      [14:0] status_out
);
  logic run;  // drive is turning
  assign run = drive_enable_in & (run_forward_in | run_reverse_in);
  // no marker input exists, so markers never move positions
  assign fb_pos_out = FB_POS;
  assign ref_pos_out = REF_POS;
  assign fb_turns_out = 16'hFFFE;
  assign ref_turns_out = 16'h8003;
  assign mode_out = mode_in;
  // healthy, running, direction running; the rest stays clear
  assign status_out = {1'b0, run & run_reverse_in, 11'h000, run, 1'b1};
endmodule // dopb_drive_model

//--- dopb_bank_bench.sv
// Purpose: self-checking bench for the parameter bank
// Assumes: strobes driven on falling edges, one access at a time
// Notes:   each strobe is lowered a cycle before the next rises
`timescale 1ns/1ps
module dopb_bank_bench;
  logic ref_clk_in = 1'b0, rst_n_in = 1'b0;
  logic par_wr_in, par_rd_in, var_wr_in, var_rd_in, prog_start_in, rt_error_in;
  logic save_req_in, undervolt_in, par_ack_out, save_out, warm_restart_out, user_trip_out;
  logic drive_enable_out, run_forward_out, jog_out, run_reverse_out;
  logic [7:0] par_menu_in, rt_error_task_in;
  logic [6:0] par_idx_in, var_idx_in;
  logic [5:0] var_set_in;
  logic [31:0] par_wdata_in, var_wdata_in, par_rdata_out, var_rdata_out, fb_pos_in, ref_pos_in;
  logic [15:0] rt_error_code_in, fb_turns_in, ref_turns_in, drive_mode_in, mode;
  logic [14:0] drive_status_in;
  logic [3:0] save_sets_out;
  logic [1:0] preset_sel_out;
  logic [3:1] app_flag_out;
  int fails = 0, n_tests = 0, k;
  int tasks[11] = '{50, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10};  // every failing task code
  int modes[5] = '{26, 27, 28, 29, 20};  // every drive mode code
  always #4 ref_clk_in = ~ref_clk_in;
  dopb_bank dut (.*);
  dopb_drive_model u_drive (.drive_enable_in(drive_enable_out), .run_forward_in(run_forward_out),
    .run_reverse_in(run_reverse_out), .mode_in(mode), .fb_pos_out(fb_pos_in),
    .fb_turns_out(fb_turns_in), .ref_pos_out(ref_pos_in), .ref_turns_out(ref_turns_in),
    .mode_out(drive_mode_in), .status_out(drive_status_in));
  // one comparison, counted
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // parameter write; outputs of the write are settled when it returns
  task automatic pw(input logic [7:0] m, input logic [6:0] i, input logic [31:0] d);
    @(negedge ref_clk_in);
    {par_menu_in, par_idx_in, par_wdata_in, par_wr_in} = {m, i, d, 1'b1};
    @(negedge ref_clk_in) par_wr_in = 1'b0;
    chk(par_ack_out, 32'h1);
  endtask
  task automatic pr(input logic [7:0] m, input logic [6:0] i, input logic [31:0] e);
    @(negedge ref_clk_in);
    {par_menu_in, par_idx_in, par_rd_in} = {m, i, 1'b1};
    @(negedge ref_clk_in) par_rd_in = 1'b0;
    chk(par_rdata_out, e);
  endtask
  task automatic vw(input logic [5:0] s, input logic [6:0] i, input logic [31:0] d);
    @(negedge ref_clk_in);
    {var_set_in, var_idx_in, var_wdata_in, var_wr_in} = {s, i, d, 1'b1};
    @(negedge ref_clk_in) var_wr_in = 1'b0;
  endtask
  task automatic vr(input logic [5:0] s, input logic [6:0] i, input logic [31:0] e);
    @(negedge ref_clk_in);
    {var_set_in, var_idx_in, var_rd_in} = {s, i, 1'b1};
    @(negedge ref_clk_in) var_rd_in = 1'b0;
    chk(var_rdata_out, e);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // a hang counts as a mismatch
  initial begin
    #200000;
    fails++;
    finish_test;
  end
  initial begin
    {par_wr_in, par_rd_in, var_wr_in, var_rd_in, prog_start_in, rt_error_in} = '0;
    {save_req_in, undervolt_in, par_menu_in, par_idx_in, var_set_in, var_idx_in} = '0;
    {par_wdata_in, var_wdata_in, rt_error_code_in, rt_error_task_in} = '0;
    mode = 16'h001A;
    repeat (2) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    pr(8'h58, 7'h01, 32'h0);
    pr(8'h58, 7'h02, 32'h0);
    // both paths reach the same word, sets do not alias
    for (k = 0; k < 6; k++) begin
      pw(8'h46 + 8'(k), 7'h63, 32'h8000_0000 | 32'(k));
      vr(6'b1 << k, 7'h63, 32'h8000_0000 | 32'(k));
      vw(6'b1 << k, 7'h00, ~32'(k));
      pr(8'h46 + 8'(k), 7'h00, ~32'(k));
    end
    pr(8'h46, 7'h00, 32'hFFFF_FFFF);
    vw(6'b00_0001, 7'h64, 32'h5555_5555);
    vr(6'b00_0010, 7'h00, 32'hFFFF_FFFE);
    vr(6'b00_0011, 7'h00, 32'h0);
    $display("register sets done");
    // the task code is read as the error handler would, right after the error
    foreach (tasks[j]) begin
      @(negedge ref_clk_in);
      {rt_error_in, rt_error_task_in, rt_error_code_in} = {1'b1, 8'(tasks[j]), 16'h3039};
      @(negedge ref_clk_in) rt_error_in = 1'b0;
      pr(8'h58, 7'h02, 32'(tasks[j]));
    end
    pr(8'h58, 7'h01, 32'h0000_270F);
    pw(8'h58, 7'h02, 32'h0000_0007);
    pr(8'h58, 7'h02, 32'h0000_000A);
    pw(8'h58, 7'h01, 32'h0000_042F);
    chk(warm_restart_out, 32'h0);
    pr(8'h58, 7'h01, 32'h0000_270F);
    pw(8'h58, 7'h01, 32'h0000_042E);
    chk(warm_restart_out, 32'h1);
    @(negedge ref_clk_in) prog_start_in = 1'b1;
    @(negedge ref_clk_in) prog_start_in = 1'b0;
    pr(8'h58, 7'h01, 32'h0);
    $display("error status done");
    pr(8'h5A, 7'h01, 32'h1234_0000);
    pr(8'h5A, 7'h02, 32'h0000_FFFE);
    pr(8'h5A, 7'h03, 32'hFEDC_8001);
    pr(8'h5A, 7'h04, 32'h0000_8003);
    pw(8'h5A, 7'h01, 32'h0);
    pw(8'h5A, 7'h02, 32'h0);
    pr(8'h5A, 7'h01, 32'h1234_0000);
    pr(8'h5A, 7'h02, 32'h0000_FFFE);
    foreach (modes[j]) begin
      mode = 16'(modes[j]);
      repeat (4) @(negedge ref_clk_in);
      pr(8'h5A, 7'h0A, 32'(modes[j]));
    end
    pw(8'h5A, 7'h0A, 32'h0);
    pr(8'h5A, 7'h0A, 32'h0000_0014);
    $display("readouts done");
    pw(8'h5A, 7'h0B, 32'h0000_0201);
    chk(drive_enable_out, 32'h1);
    pw(8'h5A, 7'h0B, 32'h0000_0000);
    chk(drive_enable_out, 32'h1);
    pw(8'h5A, 7'h0B, 32'h0000_1E0E);
    chk({run_reverse_out, jog_out, run_forward_out, drive_enable_out}, 32'hE);
    repeat (4) @(negedge ref_clk_in);
    pr(8'h5A, 7'h0B, 32'h0000_0001);
    pw(8'h5A, 7'h0B, 32'h0000_1209);
    chk({run_reverse_out, jog_out, run_forward_out, drive_enable_out}, 32'hF);
    repeat (4) @(negedge ref_clk_in);
    pr(8'h5A, 7'h0B, 32'h0000_2003);
    pw(8'h5A, 7'h0B, 32'h0000_C060);
    chk(preset_sel_out, 32'h3);
    pw(8'h5A, 7'h0B, 32'h0000_4000);
    chk(preset_sel_out, 32'h2);
    pw(8'h5A, 7'h0B, 32'h0000_0010);
    chk(user_trip_out, 32'h1);
    pw(8'h5A, 7'h0B, 32'h0000_2180);
    chk(app_flag_out, 32'h7);
    pw(8'h5A, 7'h0B, 32'h0000_0080);
    chk(app_flag_out, 32'h1);
    $display("control word done");
    @(negedge ref_clk_in) save_req_in = 1'b1;
    @(negedge ref_clk_in) save_req_in = 1'b0;
    chk({save_out, save_sets_out}, 32'h1F);
    undervolt_in = 1'b1;
    for (k = 0; k < 8 && save_out !== 1'b1; k++) @(negedge ref_clk_in);
    chk(save_out, 32'h1);
    $display("save done");
    finish_test;
  end
endmodule // dopb_bank_bench
